// ### pkg/eicp_pkg.sv
/*
  Constants for the configuration image loader: image offsets,
  signature, defaults taken when no image is present, buffer size.
  Assumes byte-wide image addressing starting at zero.
*/
package eicp_pkg;

  localparam int        IMG_BYTES     = 512;
  localparam int        ADDR_W        = 9;
  localparam int        NUM_STR       = 5;
  localparam int        NUM_PTR       = 9;
  localparam int        GPIO_W        = 11;

  localparam logic [7:0] SIG_VALUE    = 8'ha5;

  localparam logic [8:0] OFS_SIG       = 9'h000;
  localparam logic [8:0] OFS_MAC_FIRST = 9'h001;
  localparam logic [8:0] OFS_MAC_LAST  = 9'h006;
  localparam logic [8:0] OFS_FS_POLL   = 9'h007;
  localparam logic [8:0] OFS_HS_POLL   = 9'h008;
  localparam logic [8:0] OFS_CFG       = 9'h009;
  localparam logic [8:0] OFS_LANG_LO   = 9'h00a;
  localparam logic [8:0] OFS_LANG_HI   = 9'h00b;
  localparam logic [8:0] OFS_PTR_FIRST = 9'h00c;
  localparam logic [8:0] OFS_STR_LAST  = 9'h015;
  localparam logic [8:0] OFS_PTR_LAST  = 9'h01d;
  localparam logic [8:0] OFS_WAKE_LO   = 9'h01e;
  localparam logic [8:0] OFS_WAKE_HI   = 9'h01f;
  localparam logic [8:0] OFS_PME       = 9'h020;
  localparam logic [8:0] OFS_PAD       = 9'h021;

  localparam logic [47:0] MAC_DEF      = 48'hffff_ffff_ffff;
  localparam logic [7:0]  FS_POLL_DEF  = 8'h01;
  localparam logic [7:0]  HS_POLL_DEF  = 8'h04;
  localparam logic [7:0]  CFG_DEF      = 8'h04;
  localparam logic [15:0] LANG_DEF     = 16'h0000;
  localparam logic [10:0] WAKE_DEF     = 11'h000;
  localparam logic [7:0]  PME_DEF      = 8'h00;

  typedef enum logic [1:0] {LD_IDLE, LD_READ} eicp_state_type;

endpackage : eicp_pkg

// ### logic/eicp_image_ram.sv
/*
  Image buffer: one write port, one registered read port.
  Assumes a single clock; no reset of the contents.
*/
`timescale 1ns/1ps
module eicp_image_ram
  import eicp_pkg::*;
#(
  parameter int DEPTH = IMG_BYTES,
  parameter int AW    = ADDR_W
) (
  // Clock
  input  wire logic          clk_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output      logic [7:0]    rdata_out
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule : eicp_image_ram

// ### logic/eicp_loader.sv
/*
  Configuration image loader: reads the image byte by byte, decodes
  the fixed header fields, keeps the pointer table and buffers the
  image for descriptor fetches.
  Assumes a byte read port toward the serial memory controller that
  answers each request with a one-cycle acknowledge.
*/
`timescale 1ns/1ps
module eicp_loader
  import eicp_pkg::*;
#(
  parameter int IMG_SIZE = IMG_BYTES
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Reload triggers
  input  wire logic              sys_reload_in,
  input  wire logic              usb_reset_in,
  // Image byte read port
  output      logic              rd_req_out,
  output      logic [ADDR_W-1:0] rd_addr_out,
  input  wire logic              rd_ack_in,
  input  wire logic [7:0]        rd_data_in,
  // Decoded settings
  output      logic [47:0]       mac_addr_out,
  output      logic [7:0]        fs_poll_out,
  output      logic [7:0]        hs_poll_out,
  output      logic [7:0]        cfg_flags_out,
  output      logic [15:0]       lang_id_out,
  output      logic [GPIO_W-1:0] gpio_wake_en_out,
  output      logic [7:0]        pme_flags_out,
  // Status
  output      logic              image_valid_out,
  output      logic              load_done_out,
  output      logic              usb_disconnect_out,
  // Descriptor fetch
  input  wire logic              desc_req_in,
  input  wire logic [3:0]        desc_sel_in,
  input  wire logic [7:0]        desc_idx_in,
  output      logic              desc_valid_out,
  output      logic              desc_err_out,
  output      logic              desc_last_out,
  output      logic [7:0]        desc_data_out
);

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [ADDR_W-1:0] word_to_byte(input logic [7:0] w);
    word_to_byte = {w, 1'b0};
  endfunction : word_to_byte

  function automatic logic in_range(input logic [8:0] a,
                                    input logic [8:0] lo,
                                    input logic [8:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  //////////////////////////////////////////////////////////////////////////
  // Load sequencer

  eicp_state_type    st_r,  st_nxt;
  logic              full_r, full_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic              req_r, req_nxt;
  logic              valid_r, valid_nxt;
  logic              done_r, done_nxt;
  logic              disc_r, disc_nxt;
  logic [47:0]       mac_r, mac_nxt;
  logic [7:0]        fs_r, fs_nxt, hs_r, hs_nxt, cfg_r, cfg_nxt;
  logic [15:0]       lang_r, lang_nxt;
  logic [GPIO_W-1:0] wake_r, wake_nxt;
  logic [7:0]        pme_r, pme_nxt;
  logic [7:0]        len_r [NUM_PTR];
  logic [7:0]        len_nxt [NUM_PTR];
  logic [7:0]        off_r [NUM_PTR];
  logic [7:0]        off_nxt [NUM_PTR];
  logic              take, sig_bad, ram_we;
  logic [8:0]        prel;

  assign take    = (st_r == LD_READ) && rd_ack_in;
  assign sig_bad = (addr_r == OFS_SIG) && (rd_data_in != SIG_VALUE);
  assign ram_we  = take && full_r && !sig_bad;
  assign prel    = addr_r - OFS_PTR_FIRST;

  always_comb begin
    st_nxt    = st_r;
    full_nxt  = full_r;
    addr_nxt  = addr_r;
    valid_nxt = valid_r;
    done_nxt  = done_r;
    mac_nxt   = mac_r;
    fs_nxt    = fs_r;
    hs_nxt    = hs_r;
    cfg_nxt   = cfg_r;
    lang_nxt  = lang_r;
    wake_nxt  = wake_r;
    pme_nxt   = pme_r;
    len_nxt   = len_r;
    off_nxt   = off_r;
    case (st_r)
      LD_IDLE: begin
        if (sys_reload_in) begin
          st_nxt   = LD_READ;
          full_nxt = 1'b1;
          addr_nxt = OFS_SIG;
          done_nxt = 1'b0;
        end else if (usb_reset_in) begin
          st_nxt   = LD_READ;
          full_nxt = 1'b0;
          addr_nxt = OFS_SIG;
        end
      end
      LD_READ: begin
        if (take) begin
          addr_nxt = addr_r + 9'h001;
          if (sig_bad) begin
            st_nxt = LD_IDLE;
            if (full_r) begin
              valid_nxt = 1'b0;
              done_nxt  = 1'b1;
              mac_nxt   = MAC_DEF;
              fs_nxt    = FS_POLL_DEF;
              hs_nxt    = HS_POLL_DEF;
              cfg_nxt   = CFG_DEF;
              lang_nxt  = LANG_DEF;
              wake_nxt  = WAKE_DEF;
              pme_nxt   = PME_DEF;
              for (int i = 0; i < NUM_PTR; i++) begin
                len_nxt[i] = 8'h00;
                off_nxt[i] = 8'h00;
              end
            end
          end else begin
            if (addr_r == OFS_SIG && full_r) begin
              valid_nxt = 1'b1;
            end
            if (in_range(addr_r, OFS_MAC_FIRST, OFS_MAC_LAST)) begin
              mac_nxt = {mac_r[39:0], rd_data_in};
            end
            if (full_r) begin
              if (addr_r == OFS_FS_POLL) fs_nxt = rd_data_in;
              if (addr_r == OFS_HS_POLL) hs_nxt = rd_data_in;
              if (addr_r == OFS_CFG) cfg_nxt = rd_data_in;
              if (addr_r == OFS_LANG_LO) lang_nxt[7:0] = rd_data_in;
              if (addr_r == OFS_LANG_HI) lang_nxt[15:8] = rd_data_in;
              if (in_range(addr_r, OFS_PTR_FIRST, OFS_PTR_LAST)) begin
                if (prel[0]) off_nxt[prel[4:1]] = rd_data_in;
                else len_nxt[prel[4:1]] = rd_data_in;
              end
              if (addr_r == OFS_WAKE_LO) wake_nxt[7:0] = rd_data_in;
              if (addr_r == OFS_WAKE_HI) begin
                wake_nxt[10:8] = rd_data_in[2:0];
              end
              if (addr_r == OFS_PME) pme_nxt = rd_data_in;
            end
            if (full_r ? (addr_r == ADDR_W'(IMG_SIZE - 1))
                       : (addr_r == OFS_MAC_LAST)) begin
              st_nxt   = LD_IDLE;
              done_nxt = 1'b1;
            end
          end
        end
      end
      default: st_nxt = LD_IDLE;
    endcase
    req_nxt  = (st_nxt == LD_READ);
    disc_nxt = (st_nxt == LD_READ) && full_nxt;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r    <= LD_READ;
      full_r  <= 1'b1;
      addr_r  <= OFS_SIG;
      req_r   <= 1'b1;
      valid_r <= 1'b0;
      done_r  <= 1'b0;
      disc_r  <= 1'b1;
      mac_r   <= MAC_DEF;
      fs_r    <= FS_POLL_DEF;
      hs_r    <= HS_POLL_DEF;
      cfg_r   <= CFG_DEF;
      lang_r  <= LANG_DEF;
      wake_r  <= WAKE_DEF;
      pme_r   <= PME_DEF;
      for (int i = 0; i < NUM_PTR; i++) begin
        len_r[i] <= 8'h00;
        off_r[i] <= 8'h00;
      end
    end else begin
      st_r    <= st_nxt;
      full_r  <= full_nxt;
      addr_r  <= addr_nxt;
      req_r   <= req_nxt;
      valid_r <= valid_nxt;
      done_r  <= done_nxt;
      disc_r  <= disc_nxt;
      mac_r   <= mac_nxt;
      fs_r    <= fs_nxt;
      hs_r    <= hs_nxt;
      cfg_r   <= cfg_nxt;
      lang_r  <= lang_nxt;
      wake_r  <= wake_nxt;
      pme_r   <= pme_nxt;
      len_r   <= len_nxt;
      off_r   <= off_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Descriptor fetch

  logic [ADDR_W-1:0] ram_raddr;
  logic [7:0]        ram_rdata;
  logic [3:0]        sel_c;
  logic              sel_ok, fetch_err;
  logic              s1_vld_r, s1_vld_nxt, s1_err_r, s1_err_nxt;
  logic              s1_last_r, s1_last_nxt;
  logic              dv_r, dv_nxt, de_r, de_nxt, dl_r, dl_nxt;
  logic [7:0]        dd_r, dd_nxt;

  always_comb begin
    sel_ok    = desc_sel_in < 4'(NUM_PTR);
    sel_c     = sel_ok ? desc_sel_in : 4'h0;
    ram_raddr = word_to_byte(off_r[sel_c]) + ADDR_W'(desc_idx_in);
    fetch_err = !done_r || !valid_r || !sel_ok || len_r[sel_c] == 8'h00
                || desc_idx_in >= len_r[sel_c];
    s1_vld_nxt  = desc_req_in;
    s1_err_nxt  = fetch_err;
    s1_last_nxt = !fetch_err && (desc_idx_in == len_r[sel_c] - 8'h01);
    dv_nxt = s1_vld_r;
    de_nxt = s1_vld_r && s1_err_r;
    dl_nxt = s1_vld_r && s1_last_r;
    dd_nxt = (s1_vld_r && !s1_err_r) ? ram_rdata : 8'h00;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_vld_r  <= 1'b0;
      s1_err_r  <= 1'b0;
      s1_last_r <= 1'b0;
      dv_r      <= 1'b0;
      de_r      <= 1'b0;
      dl_r      <= 1'b0;
      dd_r      <= 8'h00;
    end else begin
      s1_vld_r  <= s1_vld_nxt;
      s1_err_r  <= s1_err_nxt;
      s1_last_r <= s1_last_nxt;
      dv_r      <= dv_nxt;
      de_r      <= de_nxt;
      dl_r      <= dl_nxt;
      dd_r      <= dd_nxt;
    end
  end

  eicp_image_ram #(.DEPTH(IMG_SIZE), .AW(ADDR_W)) u_ram (
    .clk_in    (clk_in),
    .we_in     (ram_we),
    .waddr_in  (addr_r),
    .wdata_in  (rd_data_in),
    .raddr_in  (ram_raddr),
    .rdata_out (ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_req_out         = req_r;
  assign rd_addr_out        = addr_r;
  assign mac_addr_out       = mac_r;
  assign fs_poll_out        = fs_r;
  assign hs_poll_out        = hs_r;
  assign cfg_flags_out      = cfg_r;
  assign lang_id_out        = lang_r;
  assign gpio_wake_en_out   = wake_r;
  assign pme_flags_out      = pme_r;
  assign image_valid_out    = valid_r;
  assign load_done_out      = done_r;
  assign usb_disconnect_out = disc_r;
  assign desc_valid_out     = dv_r;
  assign desc_err_out       = de_r;
  assign desc_last_out      = dl_r;
  assign desc_data_out      = dd_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_mac_first_byte: assert property (take && addr_r == OFS_MAC_FIRST
    |=> mac_addr_out[7:0] == $past(rd_data_in))
    else $error("MAC byte not captured");
  a_poll_fs: assert property (take && full_r && addr_r == OFS_FS_POLL
    |=> fs_poll_out == $past(rd_data_in))
    else $error("Full-speed poll interval wrong");
  a_cfg_flags: assert property (take && full_r && addr_r == OFS_CFG
    |=> cfg_flags_out == $past(rd_data_in))
    else $error("Configuration flags wrong");
  a_lang_high: assert property (take && full_r && addr_r == OFS_LANG_HI
    |=> lang_id_out[15:8] == $past(rd_data_in))
    else $error("Language ID high byte wrong");
  a_fetch_addr: assert property (desc_req_in && !fetch_err
    |-> ram_raddr == {off_r[sel_c], 1'b0} + ADDR_W'(desc_idx_in))
    else $error("Descriptor byte address wrong");
  a_absent_str: assert property (desc_req_in && sel_ok
    && len_r[sel_c] == 8'h00 |-> ##2 desc_valid_out && desc_err_out)
    else $error("Absent descriptor not refused");
  a_wake_high: assert property (take && full_r && addr_r == OFS_WAKE_HI
    |=> gpio_wake_en_out[10:8] == $past(rd_data_in[2:0]))
    else $error("High wake enables wrong");
  a_pme_flags: assert property (take && full_r && addr_r == OFS_PME
    |=> pme_flags_out == $past(rd_data_in))
    else $error("Power event flags wrong");
  a_sig_reject: assert property (take && full_r && sig_bad
    |=> !image_valid_out && load_done_out && !rd_req_out)
    else $error("Bad signature not rejected");
  a_mac_only: assert property (st_r == LD_READ && !full_r
    |=> $stable(cfg_flags_out) && $stable(lang_id_out))
    else $error("Bus reset changed settings");
  a_disc_hold: assert property (st_r == LD_READ && full_r
    |-> usb_disconnect_out && !load_done_out)
    else $error("Port connected during load");

  c_full_load: cover property (take && full_r && !sig_bad
    && addr_r == ADDR_W'(IMG_SIZE - 1));
  c_sig_fail: cover property (take && full_r && sig_bad);
  c_mac_reload: cover property (take && !full_r && addr_r == OFS_MAC_LAST);
  c_fetch_ok: cover property (desc_valid_out && !desc_err_out);

endmodule : eicp_loader

// ### test/eicp_cfg_mem_model.sv
/*
  Behavioural model of the serial configuration memory behind the
  loader's byte read port; answers after a selectable number of cycles.
  Assumes the bench fills the mem array before each load.
*/
`timescale 1ns/1ps
module eicp_cfg_mem_model
  import eicp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Byte read port
  input  wire logic              rd_req_in,
  input  wire logic [ADDR_W-1:0] rd_addr_in,
  output      logic              rd_ack_out,
  output      logic [7:0]        rd_data_out,
  // Answer delay in cycles
  input  wire logic [3:0]        wait_in
);

  logic [7:0] mem [IMG_BYTES];
  logic [3:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // One answer per request, never in the cycle after an answer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ack_out  <= 1'b0;
      rd_data_out <= 8'h00;
      cnt_r       <= 4'h0;
    end else begin
      rd_ack_out  <= 1'b0;
      // Released data toggles
      rd_data_out <= ~rd_data_out;
      if (rd_ack_out || !rd_req_in) begin
        cnt_r <= 4'h0;
      end else if (cnt_r < wait_in) begin
        cnt_r <= cnt_r + 4'h1;
      end else begin
        rd_ack_out  <= 1'b1;
        rd_data_out <= mem[rd_addr_in];
        cnt_r       <= 4'h0;
      end
    end
  end

endmodule : eicp_cfg_mem_model

// ### test/tb_eicp_loader.sv
/*
  Self-checking bench for the configuration image loader.
  Assumes the memory model above on the read port.
*/
`timescale 1ns/1ps
module tb_eicp_loader
  import eicp_pkg::*;
;
  logic              clk_in        = 1'b0;
  logic              arst_n_in     = 1'b0;
  logic              sys_reload_in = 1'b0;
  logic              usb_reset_in  = 1'b0;
  logic              desc_req_in   = 1'b0;
  logic [3:0]        desc_sel_in   = 4'h0;
  logic [7:0]        desc_idx_in   = 8'h00;
  logic [3:0]        mem_wait      = 4'h0;
  logic              rd_req_out, rd_ack, image_valid_out, load_done_out;
  logic              usb_disconnect_out, desc_valid_out, desc_err_out;
  logic              desc_last_out;
  logic [ADDR_W-1:0] rd_addr_out;
  logic [7:0]        rd_data, fs_poll_out, hs_poll_out, cfg_flags_out;
  logic [7:0]        pme_flags_out, desc_data_out;
  logic [47:0]       mac_addr_out;
  logic [15:0]       lang_id_out;
  logic [GPIO_W-1:0] gpio_wake_en_out;
  logic [7:0]        img [IMG_BYTES];
  int                bad_count     = 0;
  int                total_checks  = 0;
  localparam logic [7:0] HDR [34] = '{
    8'ha5, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h01, 8'h04, 8'h04,
    8'h09, 8'h04, 8'h0a, 8'h11, 8'h12, 8'h16, 8'h10, 8'h1f, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h12, 8'h27, 8'h12, 8'h30, 8'h12, 8'h39, 8'h12, 8'h42,
    8'h00, 8'h04, 8'h8a, 8'h00};

  eicp_loader i_eicp_loader (
    .clk_in(clk_in), .arst_n_in(arst_n_in),
    .sys_reload_in(sys_reload_in), .usb_reset_in(usb_reset_in),
    .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out),
    .rd_ack_in(rd_ack), .rd_data_in(rd_data),
    .mac_addr_out(mac_addr_out), .fs_poll_out(fs_poll_out),
    .hs_poll_out(hs_poll_out), .cfg_flags_out(cfg_flags_out),
    .lang_id_out(lang_id_out), .gpio_wake_en_out(gpio_wake_en_out),
    .pme_flags_out(pme_flags_out), .image_valid_out(image_valid_out),
    .load_done_out(load_done_out), .usb_disconnect_out(usb_disconnect_out),
    .desc_req_in(desc_req_in), .desc_sel_in(desc_sel_in),
    .desc_idx_in(desc_idx_in), .desc_valid_out(desc_valid_out),
    .desc_err_out(desc_err_out), .desc_last_out(desc_last_out),
    .desc_data_out(desc_data_out));

  eicp_cfg_mem_model i_eicp_cfg_mem_model (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .rd_req_in(rd_req_out),
    .rd_addr_in(rd_addr_out), .rd_ack_out(rd_ack), .rd_data_out(rd_data),
    .wait_in(mem_wait));

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial forever #50 clk_in = ~clk_in;

  initial begin
    #3_000_000;
    bad_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check_val(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic close_out();
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic set_mem(input int a, input logic [7:0] v);
    img[a] = v;
    i_eicp_cfg_mem_model.mem[a] = v;
  endtask : set_mem

  task automatic pulse(input logic full);
    @(posedge clk_in);
    if (full) sys_reload_in <= 1'b1;
    else usb_reset_in <= 1'b1;
    @(posedge clk_in);
    sys_reload_in <= 1'b0;
    usb_reset_in  <= 1'b0;
    @(negedge clk_in);
  endtask : pulse

  task automatic wait_idle();
    int n;
    n = 0;
    while (!(rd_req_out === 1'b0 && load_done_out === 1'b1) && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    check_val({47'h0, rd_req_out}, 48'h0);
  endtask : wait_idle

  task automatic fetch(input logic [3:0] sel, input logic [7:0] idx,
                       input logic err, input logic [7:0] data,
                       input logic last);
    int n;
    n = 0;
    @(posedge clk_in);
    desc_req_in <= 1'b1;
    desc_sel_in <= sel;
    desc_idx_in <= idx;
    @(posedge clk_in);
    desc_req_in <= 1'b0;
    @(negedge clk_in);
    while (desc_valid_out !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    check_val({37'h0, desc_valid_out, desc_err_out,
               err ? 1'b0 : desc_last_out, desc_data_out},
              {37'h0, 1'b1, err, err ? 1'b0 : last, err ? 8'h00 : data});
  endtask : fetch

  task automatic desc_sweep();
    int len;
    int base;
    for (int s = 0; s < 9; s++) begin
      len  = img[12 + 2 * s];
      base = {img[13 + 2 * s], 1'b0};
      if (len == 0) begin
        fetch(s[3:0], 8'h00, 1'b1, 8'h00, 1'b0);
      end else begin
        fetch(s[3:0], 8'h00, 1'b0, img[base], len == 1);
        fetch(s[3:0], len[7:0] - 8'h01, 1'b0, img[base + len - 1], 1'b1);
        fetch(s[3:0], len[7:0], 1'b1, 8'h00, 1'b0);
      end
    end
    fetch(4'h9, 8'h00, 1'b1, 8'h00, 1'b0);
    fetch(4'hf, 8'h00, 1'b1, 8'h00, 1'b0);
  endtask : desc_sweep

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < IMG_BYTES; i++) set_mem(i, i[7:0] ^ 8'h5a);
    for (int i = 0; i < 34; i++) set_mem(i, HDR[i]);
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    check_val({46'h0, usb_disconnect_out, load_done_out}, 48'h2);
    fetch(4'h0, 8'h00, 1'b1, 8'h00, 1'b0);
    wait_idle();
    check_val(mac_addr_out, 48'h1234_5678_9abc);
    check_val({32'h0, fs_poll_out, hs_poll_out}, 48'h0104);
    check_val({40'h0, cfg_flags_out}, 48'h04);
    check_val({32'h0, lang_id_out}, 48'h0409);
    check_val({37'h0, gpio_wake_en_out}, 48'h400);
    check_val({40'h0, pme_flags_out}, 48'h8a);
    check_val({46'h0, image_valid_out, usb_disconnect_out}, 48'h2);
    desc_sweep();
    // Bus reset with a slow memory
    for (int i = 1; i < 7; i++) set_mem(i, 8'hd0 + i[7:0]);
    set_mem(7, 8'h33);
    set_mem(12, 8'h02);
    mem_wait <= 4'h3;
    pulse(1'b0);
    check_val({46'h0, usb_disconnect_out, load_done_out}, 48'h1);
    wait_idle();
    check_val(mac_addr_out, 48'hd1d2_d3d4_d5d6);
    check_val({40'h0, fs_poll_out}, 48'h01);
    fetch(4'h0, 8'h09, 1'b0, img[8'h2b], 1'b1);
    // Full reload with a blank signature
    set_mem(0, 8'h00);
    mem_wait <= 4'h0;
    pulse(1'b1);
    check_val({46'h0, usb_disconnect_out, load_done_out}, 48'h2);
    wait_idle();
    check_val({47'h0, image_valid_out}, 48'h0);
    check_val(mac_addr_out, MAC_DEF);
    check_val({16'h0, fs_poll_out, hs_poll_out, cfg_flags_out, pme_flags_out},
              {16'h0, FS_POLL_DEF, HS_POLL_DEF, CFG_DEF, PME_DEF});
    check_val({21'h0, lang_id_out, gpio_wake_en_out},
              {21'h0, LANG_DEF, WAKE_DEF});
    fetch(4'h5, 8'h00, 1'b1, 8'h00, 1'b0);
    // Good reload, slow memory, changed image
    set_mem(0, 8'ha5);
    mem_wait <= 4'h2;
    pulse(1'b1);
    wait_idle();
    check_val({47'h0, image_valid_out}, 48'h1);
    check_val({fs_poll_out, mac_addr_out[39:0]}, 48'h33d2_d3d4_d5d6);
    fetch(4'h0, 8'h01, 1'b0, img[8'h23], 1'b1);
    fetch(4'h0, 8'h02, 1'b1, 8'h00, 1'b0);
    close_out();
  end

endmodule : tb_eicp_loader
